/* sram_pkg.sv */
package sram_pkg;

    localparam int BURST_W = 2;
    localparam int DEF_ADDR_W = 20;
    localparam int DEF_LANES = 4;
    localparam int DEF_LANE_W = 9;

    localparam logic [BURST_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BURST_W-1:0] BEAT_STEP = 2'h1;

    // Control pins, active levels as on the pins
    typedef struct packed {
        logic chip_sel_primary_n;
        logic chip_sel_second;
        logic chip_sel_third_n;
        logic processor_addr_strobe_n;
        logic controller_addr_strobe_n;
        logic burst_advance_n;
        logic global_write_n;
        logic byte_write_enable_n;
        logic oe_n;
        logic mode;
    } ctrl_t;

    localparam int CTRL_W = $bits(ctrl_t);

    localparam ctrl_t CTRL_IDLE = '{
        chip_sel_primary_n: 1'h1,
        chip_sel_second: 1'h0,
        chip_sel_third_n: 1'h1,
        processor_addr_strobe_n: 1'h1,
        controller_addr_strobe_n: 1'h1,
        burst_advance_n: 1'h1,
        global_write_n: 1'h1,
        byte_write_enable_n: 1'h1,
        oe_n: 1'h1,
        mode: 1'h1
    };

    typedef enum logic {
        ST_DESELECTED,
        ST_SELECTED
    } acc_state_t;

    typedef enum logic [2:0] {
        K_IDLE,
        K_DESELECT,
        K_START_READ,
        K_START_WRITE,
        K_NEXT_READ,
        K_NEXT_WRITE
    } acc_kind_t;

    // Low address bits of a beat; the 2-bit sum wraps by itself
    function automatic logic [BURST_W-1:0] burst_addr(
        input logic [BURST_W-1:0] start,
        input logic [BURST_W-1:0] count,
        input logic interleave
    );
        if (interleave) begin
            burst_addr = start ^ count;
        end else begin
            burst_addr = start + count;
        end
    endfunction : burst_addr

endpackage : sram_pkg

/* sram_mem.sv */
module sram_mem #(
    parameter int ADDR_W = sram_pkg::DEF_ADDR_W,
    parameter int LANES = sram_pkg::DEF_LANES,
    parameter int LANE_W = sram_pkg::DEF_LANE_W
) (
    input wire logic clock_i,                     // System clock
    input wire logic we_i,                        // Write this cycle
    input wire logic [LANES-1:0] lane_en_i,       // Lanes to write
    input wire logic re_i,                        // Read this cycle
    input wire logic [ADDR_W-1:0] addr_i,         // Word address
    input wire logic [LANES*LANE_W-1:0] wdata_i,  // Write data
    output logic [LANES*LANE_W-1:0] rdata_o       // Registered read data
);

    logic [LANES*LANE_W-1:0] mem [0:(2**ADDR_W)-1];

    // No reset: array and read register hold contents like the real cells
    always_ff @(posedge clock_i) begin
        if (re_i) begin
            rdata_o <= mem[addr_i];
        end
        // One process owns the whole array; lanes are masked inside it
        for (int l = 0; l < LANES; l++) begin
            if (we_i && lane_en_i[l]) begin
                mem[addr_i][l*LANE_W +: LANE_W] <= wdata_i[l*LANE_W +: LANE_W];
            end
        end
    end

endmodule : sram_mem

/* sram_access.sv */
module sram_access #(
    parameter int ADDR_W = sram_pkg::DEF_ADDR_W,
    parameter int LANES = sram_pkg::DEF_LANES,
    parameter int LANE_W = sram_pkg::DEF_LANE_W
) (
    input wire logic clock_i,                     // System clock, 20 MHz
    input wire logic rst_i,                       // Synchronous reset, high
    input wire logic [ADDR_W-1:0] addr_i,         // Address pins
    input wire logic [LANES*LANE_W-1:0] data_i,   // Data bus, input side
    input wire logic chip_sel_primary_n_i,        // Primary select, low
    input wire logic chip_sel_second_i,           // Second select, high
    input wire logic chip_sel_third_n_i,          // Third select, low
    input wire logic processor_addr_strobe_n_i,   // Processor strobe, low
    input wire logic controller_addr_strobe_n_i,  // Controller strobe, low
    input wire logic burst_advance_n_i,           // Advance, low
    input wire logic global_write_n_i,            // Global write, low
    input wire logic byte_write_enable_n_i,       // Byte write enable, low
    input wire logic [LANES-1:0] byte_lane_select_n_i, // Lane selects, low
    input wire logic output_enable_n_i,           // Output enable, low
    input wire logic burst_order_i,               // 1 interleaved, 0 linear
    output logic [LANES*LANE_W-1:0] data_o,       // Data bus, output side
    output logic data_oe_n_o                      // Data drive, low drives
);

    localparam int DATA_W = LANES * LANE_W;
    localparam int IN_W = ADDR_W + DATA_W + LANES + sram_pkg::CTRL_W;
    localparam int CTRL_LO = 0;
    localparam int LANE_LO = CTRL_LO + sram_pkg::CTRL_W;
    localparam int DATA_LO = LANE_LO + LANES;
    localparam int ADDR_LO = DATA_LO + DATA_W;

    if (LANES < 1 || LANE_W < 1 || ADDR_W <= sram_pkg::BURST_W) begin : g_check
        $error("sram_access: unsupported parameter values");
    end

    typedef struct packed {
        logic [IN_W-1:0] s1;
        logic [IN_W-1:0] s2;
        logic [IN_W-1:0] s3;
        logic [IN_W-1:0] filt;
        sram_pkg::acc_state_t state;
        logic [ADDR_W-1:0] base;
        logic [sram_pkg::BURST_W-1:0] count;
        logic interleave;
        logic dq_oe_n;
    } state_t;

    localparam logic [IN_W-1:0] IN_IDLE = {
        {ADDR_W{1'h0}},
        {DATA_W{1'h0}},
        {LANES{1'h1}},
        sram_pkg::CTRL_IDLE
    };

    localparam state_t STATE_RST = '{
        s1: IN_IDLE,
        s2: IN_IDLE,
        s3: IN_IDLE,
        filt: IN_IDLE,
        state: sram_pkg::ST_DESELECTED,
        base: '0,
        count: sram_pkg::BEAT_FIRST,
        interleave: 1'h1,
        dq_oe_n: 1'h1
    };

    // A bit moves only when the last two stages agree
    function automatic logic [IN_W-1:0] settle(
        input logic [IN_W-1:0] held,
        input logic [IN_W-1:0] b,
        input logic [IN_W-1:0] c
    );
        settle = (held & (b ^ c)) | (c & ~(b ^ c));
    endfunction : settle

    function automatic logic write_seen(
        input sram_pkg::ctrl_t c,
        input logic [LANES-1:0] lane_n
    );
        write_seen = !c.global_write_n || (!c.byte_write_enable_n && (lane_n != {LANES{1'h1}}));
    endfunction : write_seen

    function automatic logic [LANES-1:0] lane_mask(
        input sram_pkg::ctrl_t c,
        input logic [LANES-1:0] lane_n
    );
        if (!c.global_write_n) begin
            lane_mask = {LANES{1'h1}};
        end else if (!c.byte_write_enable_n) begin
            lane_mask = ~lane_n;
        end else begin
            lane_mask = '0;
        end
    endfunction : lane_mask

    state_t r;
    state_t nx;

    logic [IN_W-1:0] pins;
    sram_pkg::ctrl_t fc;
    logic [LANES-1:0] f_lane_n;
    logic [DATA_W-1:0] f_data;
    logic [ADDR_W-1:0] f_addr;

    logic cs_ok;
    logic p_start;
    logic c_start;
    logic wr_now;
    logic from_desel;
    logic [sram_pkg::BURST_W-1:0] cnt_step;
    logic [sram_pkg::BURST_W-1:0] cnt_use;
    sram_pkg::acc_kind_t kind;

    logic mem_we;
    logic mem_re;
    logic [LANES-1:0] mem_lane;
    logic [ADDR_W-1:0] mem_addr;

    assign pins = {
        addr_i,
        data_i,
        byte_lane_select_n_i,
        chip_sel_primary_n_i,
        chip_sel_second_i,
        chip_sel_third_n_i,
        processor_addr_strobe_n_i,
        controller_addr_strobe_n_i,
        burst_advance_n_i,
        global_write_n_i,
        byte_write_enable_n_i,
        output_enable_n_i,
        burst_order_i
    };

    assign fc = r.filt[LANE_LO-1:CTRL_LO];
    assign f_lane_n = r.filt[DATA_LO-1:LANE_LO];
    assign f_data = r.filt[ADDR_LO-1:DATA_LO];
    assign f_addr = r.filt[IN_W-1:ADDR_LO];

    // Access decode on the settled pin values
    always_comb begin
        cs_ok = !fc.chip_sel_primary_n && fc.chip_sel_second && !fc.chip_sel_third_n;
        p_start = !fc.processor_addr_strobe_n && !fc.chip_sel_primary_n;
        c_start = !fc.controller_addr_strobe_n && !p_start;
        wr_now = write_seen(fc, f_lane_n);
        from_desel = (r.state == sram_pkg::ST_DESELECTED);
        cnt_step = r.count + sram_pkg::BEAT_STEP;
        cnt_use = fc.burst_advance_n ? r.count : cnt_step;
        if (p_start || c_start) begin
            if (!cs_ok) begin
                kind = sram_pkg::K_DESELECT;
            end else if (c_start && wr_now) begin
                kind = sram_pkg::K_START_WRITE;
            end else begin
                // Write controls are not looked at on a processor start
                kind = sram_pkg::K_START_READ;
            end
        end else if (!from_desel) begin
            if (wr_now) begin
                kind = sram_pkg::K_NEXT_WRITE;
            end else begin
                kind = sram_pkg::K_NEXT_READ;
            end
        end else begin
            kind = sram_pkg::K_IDLE;
        end
    end

    always_comb begin
        nx = r;
        mem_we = 1'h0;
        mem_re = 1'h0;
        mem_lane = '0;
        mem_addr = f_addr;
        nx.s1 = pins;
        nx.s2 = r.s1;
        nx.s3 = r.s2;
        nx.filt = settle(r.filt, r.s2, r.s3);
        case (kind)
            sram_pkg::K_DESELECT: begin
                nx.state = sram_pkg::ST_DESELECTED;
                nx.dq_oe_n = 1'h1;
            end
            sram_pkg::K_START_READ: begin
                // Advance is ignored on every start
                nx.state = sram_pkg::ST_SELECTED;
                nx.base = f_addr;
                nx.count = sram_pkg::BEAT_FIRST;
                nx.interleave = fc.mode;
                mem_addr = f_addr;
                mem_re = 1'h1;
                if (from_desel) begin
                    nx.dq_oe_n = 1'h1;
                end else begin
                    nx.dq_oe_n = fc.oe_n;
                end
            end
            sram_pkg::K_START_WRITE: begin
                nx.state = sram_pkg::ST_SELECTED;
                nx.base = f_addr;
                nx.count = sram_pkg::BEAT_FIRST;
                nx.interleave = fc.mode;
                mem_addr = f_addr;
                mem_we = 1'h1;
                mem_lane = lane_mask(fc, f_lane_n);
                nx.dq_oe_n = 1'h1;
            end
            sram_pkg::K_NEXT_READ: begin
                nx.count = cnt_use;
                mem_addr = {r.base[ADDR_W-1:sram_pkg::BURST_W],
                            sram_pkg::burst_addr(r.base[sram_pkg::BURST_W-1:0], cnt_use, r.interleave)};
                mem_re = 1'h1;
                nx.dq_oe_n = fc.oe_n;
            end
            sram_pkg::K_NEXT_WRITE: begin
                nx.count = cnt_use;
                mem_addr = {r.base[ADDR_W-1:sram_pkg::BURST_W],
                            sram_pkg::burst_addr(r.base[sram_pkg::BURST_W-1:0], cnt_use, r.interleave)};
                mem_we = 1'h1;
                mem_lane = lane_mask(fc, f_lane_n);
                nx.dq_oe_n = 1'h1;
            end
            default: begin
                nx.dq_oe_n = 1'h1;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            r <= STATE_RST;
        end else begin
            r <= nx;
        end
    end

    // Read register of the array doubles as the output register
    sram_mem #(
        .ADDR_W(ADDR_W),
        .LANES(LANES),
        .LANE_W(LANE_W)
    ) u_mem (
        .clock_i(clock_i),
        .we_i(mem_we),
        .lane_en_i(mem_lane),
        .re_i(mem_re),
        .addr_i(mem_addr),
        .wdata_i(f_data),
        .rdata_o(data_o)
    );

    assign data_oe_n_o = r.dq_oe_n;

endmodule : sram_access

/* sram_access_monitor.sv */
module sram_access_monitor #(
    parameter int ADDR_W = sram_pkg::DEF_ADDR_W,
    parameter int LANES = sram_pkg::DEF_LANES,
    parameter int LANE_W = sram_pkg::DEF_LANE_W
) (
    input wire logic clock_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic chip_sel_primary_n_i, // Select
    input wire logic chip_sel_second_i, // Select
    input wire logic processor_addr_strobe_n_i, // Strobe
    input wire logic controller_addr_strobe_n_i, // Strobe
    input wire logic global_write_n_i, // Write
    input wire logic byte_write_enable_n_i, // Write
    input wire logic [LANES-1:0] byte_lane_select_n_i, // Lanes
    input wire logic output_enable_n_i, // Enable
    input wire logic data_oe_n_o // Drive
);
    // Pin pipeline is deep; judge a pin state only once held long
    logic [5:0] hold;
    logic [3:0] run_r [6];
    assign hold[0] = output_enable_n_i;
    assign hold[1] = !global_write_n_i && processor_addr_strobe_n_i;
    assign hold[2] = chip_sel_primary_n_i && !controller_addr_strobe_n_i;
    assign hold[3] = !processor_addr_strobe_n_i && !chip_sel_primary_n_i && !chip_sel_second_i;
    assign hold[4] = !byte_write_enable_n_i && !(&byte_lane_select_n_i) && processor_addr_strobe_n_i;
    assign hold[5] = hold[1] && !controller_addr_strobe_n_i;
    always_ff @(posedge clock_i) begin
        for (int i = 0; i < 6; i++) begin
            if (rst_i || !hold[i]) begin
                run_r[i] <= 4'h0;
            end else if (run_r[i] != 4'hF) begin
                run_r[i] <= run_r[i] + 4'h1;
            end
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_release;
        $fell(rst_i);
    endsequence
    chk_reset_idle: assert property (disable iff (1'b0) rst_i |=> data_oe_n_o)
        else $error("drive during reset");
    chk_release_quiet: assert property (disable iff (1'b0) s_release |-> data_oe_n_o [*3])
        else $error("drive too soon after reset");
    chk_oe_high_tri: assert property (run_r[0] >= 4'h7 |-> data_oe_n_o)
        else $error("drive with enable high");
    chk_write_tri: assert property (run_r[1] >= 4'h7 |-> data_oe_n_o)
        else $error("drive during write");
    chk_desel_ctrl: assert property (run_r[2] >= 4'h7 |-> data_oe_n_o)
        else $error("drive after deselect");
    chk_desel_proc: assert property (run_r[3] >= 4'h7 |-> data_oe_n_o)
        else $error("drive after processor deselect");
    chk_byte_tri: assert property (run_r[4] >= 4'h7 |-> data_oe_n_o)
        else $error("drive during byte write");
    chk_ctrl_write: assert property (run_r[5] >= 4'h7 |-> data_oe_n_o)
        else $error("drive during controller write");
endmodule : sram_access_monitor

bind sram_access sram_access_monitor #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) sram_access_monitor_inst (.*);

/* sram_ctrl_model.sv */
module sram_ctrl_model #(
    parameter int AW = 8
) (
    input wire logic clock_i, // Clock
    output sram_pkg::ctrl_t c_o, // Controls
    output logic [AW-1:0] a_o, // Address
    output logic [35:0] d_o, // Write data
    output logic [3:0] ln_o // Lane selects
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        c_o = sram_pkg::CTRL_IDLE;
        a_o = '0;
        d_o = 36'h0;
        ln_o = 4'hF;
    end
    // Holds one bus cycle for n clocks
    task put(input sram_pkg::ctrl_t c, input logic [AW-1:0] a, input logic [35:0] d,
        input logic [3:0] ln, input int n);
        @(posedge clock_i);
        #5;
        c_o = c;
        a_o = a;
        ln_o = ln;
        if (!c.global_write_n || (!c.byte_write_enable_n && !(&ln))) begin
            c_o.oe_n = 1'b1;
            d_o = d;
        end else begin
            d_o = ~d_o; // Released bus shows no stale value
        end
        repeat (n - 1) @(posedge clock_i);
    endtask : put
endmodule : sram_ctrl_model

/* tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [7:0] a; logic [35:0] d; logic gw; logic byte_write_enable; logic [3:0] ln;} row_t;
    sram_pkg::ctrl_t c;
    sram_pkg::ctrl_t v;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] a;
    logic [3:0] ln;
    logic [35:0] d;
    logic [35:0] data_o;
    logic [35:0] exp_mem [256];
    logic data_oe_n_o;
    logic [1:0] e;
    int errors = 0;
    int checked = 0;
    row_t rows [6] = '{'{8'h0A, 36'h123456789, 1'b0, 1'b1, 4'hF}, '{8'h0A, 36'hFFFFFFFFF, 1'b1, 1'b0, 4'hE},
        '{8'h0A, 36'h000000000, 1'b0, 1'b0, 4'h5}, '{8'h0B, 36'hABCDEF012, 1'b0, 1'b1, 4'hF},
        '{8'h0B, 36'h555555555, 1'b1, 1'b0, 4'h5}, '{8'h0B, 36'h000000000, 1'b1, 1'b1, 4'h0}};
    initial forever #25 clock_i = ~clock_i;
    sram_ctrl_model #(.AW(8)) sram_ctrl_model_inst (.clock_i(clock_i), .c_o(c), .a_o(a), .d_o(d), .ln_o(ln));
    sram_access #(.ADDR_W(8)) sram_access_inst (.clock_i(clock_i), .rst_i(rst_i), .addr_i(a), .data_i(d),
        .chip_sel_primary_n_i(c.chip_sel_primary_n), .chip_sel_second_i(c.chip_sel_second),
        .chip_sel_third_n_i(c.chip_sel_third_n), .processor_addr_strobe_n_i(c.processor_addr_strobe_n),
        .controller_addr_strobe_n_i(c.controller_addr_strobe_n), .burst_advance_n_i(c.burst_advance_n),
        .global_write_n_i(c.global_write_n), .byte_write_enable_n_i(c.byte_write_enable_n),
        .byte_lane_select_n_i(ln), .output_enable_n_i(c.oe_n), .burst_order_i(c.mode),
        .data_o(data_o), .data_oe_n_o(data_oe_n_o));
    task summarize;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task chk(input string n, input logic [35:0] s, input logic [35:0] x);
        checked++;
        if (s !== x) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    function sram_pkg::ctrl_t cw(input logic ps, cs, burst_advance, gw, byte_write_enable, oe, md);
        cw = {3'h2, ps, cs, burst_advance, gw, byte_write_enable, oe, md};
    endfunction : cw
    task put(input sram_pkg::ctrl_t x, input logic [7:0] ad, input logic [35:0] dd, input logic [3:0] l, input int n);
        sram_ctrl_model_inst.put(x, ad, dd, l, n);
        // Step off the edge so outputs are looked at once settled
        #1;
    endtask : put
    // Controller-strobe write, held, then drive must be off
    task wc(input logic [7:0] ad, input logic [35:0] dd, input logic gw, byte_write_enable, input logic [3:0] l);
        put(cw(1, 0, 1, gw, byte_write_enable, 1, 1), ad, dd, l, 8);
        for (int i = 0; i < 4; i++) begin
            if (!gw || (!byte_write_enable && !l[i])) exp_mem[ad][i*9+:9] = dd[i*9+:9];
        end
        chk("drive", {35'h0, data_oe_n_o}, 36'h1);
    endtask : wc
    task rd(input logic [7:0] ad, input logic md);
        put(cw(1, 0, 1, 1, 1, 0, md), ad, 36'h0, 4'hF, 8);
        chk("read", data_o, exp_mem[ad]);
        chk("drive", {35'h0, data_oe_n_o}, 36'h0);
    endtask : rd
    initial begin
        repeat (4000) @(posedge clock_i);
        errors++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clock_i);
        #5 rst_i = 1'b0;
        foreach (rows[i]) begin
            wc(rows[i].a, rows[i].d, rows[i].gw, rows[i].byte_write_enable, rows[i].ln);
            rd(rows[i].a, 1'b1);
        end
        $display("table done");
        wc(8'h14, 36'h111111111, 1'b0, 1'b1, 4'hF);
        put(cw(0, 0, 1, 0, 0, 1, 1), 8'h14, 36'h0F0F0F0F0, 4'h0, 2);
        rd(8'h14, 1'b1);
        put(cw(0, 1, 1, 1, 1, 1, 1), 8'h15, 36'h0, 4'hF, 2);
        put(cw(1, 1, 1, 0, 1, 1, 1), 8'h00, 36'h2468ACE13, 4'hF, 2);
        exp_mem[8'h15] = 36'h2468ACE13;
        rd(8'h15, 1'b1);
        v = cw(1, 0, 1, 1, 1, 0, 1);
        v.chip_sel_primary_n = 1'b1;
        put(v, 8'h14, 36'h0, 4'hF, 8);
        chk("deselect", {35'h0, data_oe_n_o}, 36'h1);
        rd(8'h14, 1'b1);
        v = cw(0, 1, 1, 1, 1, 0, 1);
        v.chip_sel_second = 1'b0;
        put(v, 8'h14, 36'h0, 4'hF, 8);
        chk("proc deselect", {35'h0, data_oe_n_o}, 36'h1);
        put(cw(0, 1, 1, 1, 1, 0, 1), 8'h14, 36'h0, 4'hF, 6);
        chk("first beat", {35'h0, data_oe_n_o}, 36'h1);
        put(cw(1, 1, 1, 1, 1, 0, 1), 8'h00, 36'h0, 4'hF, 8);
        chk("after first", {35'h0, data_oe_n_o}, 36'h0);
        chk("proc read", data_o, exp_mem[8'h14]);
        $display("strobe tests done");
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 4; k++) wc(8'h28 + 8'(k), 36'hABC000000 + 36'(k), 1'b0, 1'b1, 4'hF);
            put(cw(1, 0, 1, 1, 1, 0, m[0]), 8'h29, 36'h0, 4'hF, 2);
            for (int b = 1; b < 5; b++) begin
                // Shortest pulse the pin filter passes is two clocks; three steps reach every beat
                put(cw(1, 1, 0, 1, 1, 0, m[0]), 8'h00, 36'h0, 4'hF, 3);
                put(cw(1, 1, 1, 1, 1, 0, m[0]), 8'h00, 36'h0, 4'hF, 6);
                e = m[0] ? (2'h1 ^ 2'(3 * b)) : (2'h1 + 2'(3 * b));
                chk("burst", data_o, exp_mem[{6'h0A, e}]);
            end
        end
        $display("burst tests done");
        @(posedge clock_i);
        #5 rst_i = 1'b1;
        repeat (2) @(posedge clock_i);
        #5 rst_i = 1'b0;
        chk("reset drive", {35'h0, data_oe_n_o}, 36'h1);
        put(cw(1, 1, 1, 1, 1, 0, 1), 8'h00, 36'h0, 4'hF, 8);
        chk("idle after reset", {35'h0, data_oe_n_o}, 36'h1);
        $display("reset test done");
        summarize();
    end
endmodule : tb
